/* common/ltf_cfg.svh */
// Constants for the local timing and framing block
`ifndef LTF_CFG_SVH
`define LTF_CFG_SVH

// ----------------------------------------
// Clocking
// ----------------------------------------
`define LTF_SYS_CLK_KHZ 18'h30d40
`define LTF_MASTER_CLK_KHZ 18'h04000
`define LTF_FRAME_LOW_FROM 11'h7fe
`define LTF_FRAME_LOW_TO 11'h002
`define LTF_HALF_FRAME 11'h400

// ----------------------------------------
// Timeslot and frame lengths in master states, delay bounds in timeslots
// ----------------------------------------
`define LTF_TS_2M 11'h040
`define LTF_TS_4M 11'h020
`define LTF_TS_8M 11'h010
`define LTF_FRAME_LEN 12'h800
`define LTF_DMIN_2M 12'h002
`define LTF_DMIN_4M 12'h003
`define LTF_DMIN_8M 12'h005
`define LTF_DMAX_2M 12'h002
`define LTF_DMAX_4M 12'h005
`define LTF_DMAX_8M 12'h00b

// ----------------------------------------
// Group mode register fields
// ----------------------------------------
`define LTF_MD_START_HI 2:0
`define LTF_MD_WIDTH_BIT 3
`define LTF_MD_SPACE 5:4
`define LTF_MD_MODE 7:6
`define LTF_SPACE_2M 2'h0
`define LTF_SPACE_4M 2'h1

// ----------------------------------------
// Buffer
// ----------------------------------------
`define LTF_FIFO_WIDTH 32
`define LTF_FIFO_DEPTH 8
`define LTF_POL_RESET 4'h0

`endif

/* common/ltf_pkg.sv */
// Types for the local timing and framing block
package ltf_pkg;
    typedef enum logic [2:0] {
        LTF_CM_FREE = 3'h0, LTF_CM_F1 = 3'h1, LTF_CM_F2 = 3'h2,
        LTF_CM_F3 = 3'h3, LTF_CM_SLAVE = 3'h4, LTF_CM_P5 = 3'h5,
        LTF_CM_P6 = 3'h6, LTF_CM_P7 = 3'h7
    } ltf_clk_mode_t;
    typedef enum logic [1:0] {
        LTF_SER_ONE = 2'h0, LTF_SER_TWO = 2'h1,
        LTF_SER_THREE = 2'h2, LTF_SER_FOUR = 2'h3
    } ltf_ser_cfg_t;
    typedef enum logic [1:0] {
        LTF_FRM_STATIC = 2'h0, LTF_FRM_ENABLES = 2'h1,
        LTF_FRM_PULSE = 2'h2, LTF_FRM_PULSE_INV = 2'h3
    } ltf_frm_mode_t;
    typedef enum logic [1:0] {
        LTF_R2 = 2'h0, LTF_R4 = 2'h1, LTF_R8 = 2'h2, LTF_RNONE = 2'h3
    } ltf_rate_t;
endpackage

/* src/ltf_top.sv */
// Local timing, serial multiplexing and framing generator with its FIFO
`timescale 1ns/1ps
`default_nettype none
`include "ltf_cfg.svh"

// ----------------------------------------
// Transmit FIFO
// ----------------------------------------
module ltf_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic [WIDTH-1:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic push, pop;

    assign wr_ready = (wr_ptr[AW] == rd_ptr[AW]) ||
                      (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
    assign rd_valid = (wr_ptr != rd_ptr);
    assign rd_data = mem[rd_ptr[AW-1:0]];

    always_comb begin
        push = wr_valid && wr_ready;
        pop = rd_valid && rd_ready;
        next_wr_ptr = wr_ptr + (AW+1)'(push);
        next_rd_ptr = rd_ptr + (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= wr_data;
        end
    end
endmodule

// ----------------------------------------
// Top
// ----------------------------------------
module ltf_top (
    input wire logic CLOCK_IN,
    input wire logic SRST_IN,
    input wire ltf_pkg::ltf_clk_mode_t CLOCK_MODE_IN,
    input wire logic BUS_MASTER_ENABLE_IN,
    input wire logic BUS_FRAME_IN,
    input wire logic SECONDARY_FRAME_REF_IN,
    input wire logic EXT_FRAME_REF_A_IN,
    input wire logic EXT_FRAME_REF_B_IN,
    input wire logic DMA_WRITE_ACK_IN,
    input wire logic DMA_READ_ACK_IN,
    input wire logic [3:0] LOCAL_CLOCK_POLARITY_IN,
    output logic [3:0] LOCAL_CLOCK_STATUS_OUT,
    input wire ltf_pkg::ltf_ser_cfg_t SERIAL_LAYOUT_IN,
    input wire logic [31:0] TX_DATA_IN,
    input wire logic TX_VALID_IN,
    output logic TX_READY_OUT,
    output logic [31:0] RX_DATA_OUT,
    output logic RX_VALID_OUT,
    input wire logic [3:0] LOCAL_SERIAL_IN,
    output logic [3:0] LOCAL_SERIAL_OUT,
    input wire logic [7:0] GROUP_A_START_IN,
    input wire logic [7:0] GROUP_A_MODE_IN,
    input wire logic [7:0] GROUP_B_START_IN,
    input wire logic [7:0] GROUP_B_MODE_IN,
    input wire logic [7:0] BUS_OUT_DRIVE_EN_IN,
    input wire logic [7:0] BUS_IN_DRIVE_EN_IN,
    output logic [11:0] FRAMING_GROUP_A_OUT,
    output logic [11:0] FRAMING_GROUP_B_OUT,
    output logic LOCAL_FRAME_CLOCK_OUT,
    output logic LOCAL_CLOCK_2M_OUT,
    output logic LOCAL_CLOCK_4M_OUT,
    output logic LOCAL_CLOCK_8M_OUT,
    output logic FRAME_PULSE_BAR_OUT,
    output logic BUS_MASTER_OUT,
    output logic [1:0] APLL_SOURCE_OUT,
    output logic DPLL_CLOCK_OUT,
    output logic [10:0] FRAME_STATE_OUT,
    input wire ltf_pkg::ltf_rate_t DELAY_IN_RATE_IN,
    input wire ltf_pkg::ltf_rate_t DELAY_OUT_RATE_IN,
    output logic [11:0] DELAY_MIN_OUT,
    output logic [11:0] DELAY_MAX_OUT
);
    import ltf_pkg::*;

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (SRST_IN);

    // ----------------------------------------
    // Shared decoders
    // ----------------------------------------
    function automatic ltf_rate_t pin_rate(ltf_ser_cfg_t c, int p);
        pin_rate = LTF_RNONE;
        unique case (c)
            LTF_SER_ONE: pin_rate = LTF_R2;
            LTF_SER_TWO: if (p == 0 || p == 2) pin_rate = LTF_R4;
            LTF_SER_THREE: if (p == 0) pin_rate = LTF_R8;
            LTF_SER_FOUR: begin
                if (p < 2) pin_rate = LTF_R2;
                else if (p == 2) pin_rate = LTF_R4;
            end
        endcase
    endfunction

    // Position of a pin bit inside the 32-bit slot word: byte*8 + bit
    function automatic logic [4:0] bit_pos(ltf_rate_t r, int p, logic [5:0] o);
        logic [1:0] byt;
        logic [2:0] b;
        byt = 2'(p);
        b = 3'h7 - o[5:3];
        if (r == LTF_R4) begin
            byt = 2'(p) + {1'b0, o[5]};
            b = 3'h7 - o[4:2];
        end else if (r == LTF_R8) begin
            byt = o[5:4];
            b = 3'h7 - o[3:1];
        end
        bit_pos = {byt, b};
    endfunction

    function automatic logic cell_end(ltf_rate_t r, logic [5:0] o);
        unique case (r)
            LTF_R2: cell_end = (o[2:0] == 3'h7);
            LTF_R4: cell_end = (o[1:0] == 2'h3);
            LTF_R8: cell_end = o[0];
            LTF_RNONE: cell_end = 1'b0;
        endcase
    endfunction

    function automatic logic [10:0] ts_len(ltf_rate_t r);
        ts_len = (r == LTF_R2) ? `LTF_TS_2M :
                 (r == LTF_R4) ? `LTF_TS_4M : `LTF_TS_8M;
    endfunction

    function automatic logic fg_bit(logic [7:0] st, logic [7:0] md,
                                    int i, logic [10:0] cnt,
                                    logic [7:0] en);
        logic [10:0] diff;
        logic [10:0] sp;
        logic [10:0] w;
        logic [10:0] lo;
        logic pulse;
        diff = cnt - {md[`LTF_MD_START_HI], st};
        sp = (md[`LTF_MD_SPACE] == `LTF_SPACE_2M) ? `LTF_TS_2M :
             (md[`LTF_MD_SPACE] == `LTF_SPACE_4M) ? `LTF_TS_4M : `LTF_TS_8M;
        w = md[`LTF_MD_WIDTH_BIT] ? sp : (sp >> 3);
        lo = 11'(i * sp);
        pulse = (diff >= lo) && (diff < lo + w);
        unique case (ltf_frm_mode_t'(md[`LTF_MD_MODE]))
            LTF_FRM_STATIC: fg_bit = (i < 8) ? st[i % 8] : md[i % 4];
            LTF_FRM_ENABLES: fg_bit = (i < 4) ? st[i % 8] : !en[(i + 4) % 8];
            LTF_FRM_PULSE: fg_bit = pulse;
            LTF_FRM_PULSE_INV: fg_bit = !pulse;
        endcase
    endfunction

    // ----------------------------------------
    // Master tick and frame counter
    // ----------------------------------------
    logic [17:0] acc, next_acc;
    logic [10:0] state, next_state;
    logic tick, next_tick, st_new;
    logic [1:0] adj, next_adj;
    logic ref_q, next_ref_q, ref_sel, ref_rise;

    always_comb begin
        unique case (CLOCK_MODE_IN[1:0])
            2'h1: ref_sel = SECONDARY_FRAME_REF_IN;
            2'h2: ref_sel = EXT_FRAME_REF_A_IN;
            2'h3: ref_sel = EXT_FRAME_REF_B_IN;
            default: ref_sel = !BUS_FRAME_IN;
        endcase
        next_ref_q = ref_sel;
        ref_rise = ref_sel && !ref_q;
        next_acc = acc + `LTF_MASTER_CLK_KHZ;
        next_tick = 1'b0;
        if (next_acc >= `LTF_SYS_CLK_KHZ) begin
            next_acc = next_acc - `LTF_SYS_CLK_KHZ;
            next_tick = 1'b1;
        end
        next_state = state;
        next_adj = adj;
        if (next_tick) begin
            next_adj = 2'h0;
            if (adj == 2'h1) next_state = state;
            else if (adj == 2'h2) next_state = state + 11'h002;
            else next_state = state + 11'h001;
        end
        if (ref_rise) begin
            if (CLOCK_MODE_IN[2] && CLOCK_MODE_IN != LTF_CM_FREE) begin
                // Hard realign; also used by bus slave mode
                next_state = '0;
                next_acc = '0;
                next_tick = 1'b0;
            end else if (CLOCK_MODE_IN != LTF_CM_FREE && state != '0) begin
                // One state nudge per frame: frequency held, phase may drift
                next_adj = (state >= `LTF_HALF_FRAME) ? 2'h2 : 2'h1;
            end
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            acc <= '0;
            state <= '0;
            tick <= 1'b0;
            adj <= 2'h0;
            ref_q <= 1'b0;
        end else begin
            acc <= next_acc;
            state <= next_state;
            tick <= next_tick;
            adj <= next_adj;
            ref_q <= next_ref_q;
        end
    end
    assign st_new = tick;

    // ----------------------------------------
    // Clock outputs, mastership, status
    // ----------------------------------------
    logic frame_raw;
    logic [1:0] next_apll;

    always_comb begin
        frame_raw = !(state >= `LTF_FRAME_LOW_FROM ||
                      state < `LTF_FRAME_LOW_TO);
        unique case (CLOCK_MODE_IN)
            LTF_CM_FREE: next_apll = 2'h0;
            LTF_CM_SLAVE: next_apll = 2'h1;
            default: next_apll = 2'h2;
        endcase
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            LOCAL_FRAME_CLOCK_OUT <= 1'b1;
            LOCAL_CLOCK_2M_OUT <= 1'b0;
            LOCAL_CLOCK_4M_OUT <= 1'b0;
            LOCAL_CLOCK_8M_OUT <= 1'b0;
            FRAME_PULSE_BAR_OUT <= 1'b1;
            BUS_MASTER_OUT <= 1'b0;
            APLL_SOURCE_OUT <= 2'h0;
            DPLL_CLOCK_OUT <= 1'b0;
            LOCAL_CLOCK_STATUS_OUT <= 4'h0;
            FRAME_STATE_OUT <= '0;
        end else begin
            LOCAL_FRAME_CLOCK_OUT <= frame_raw ^ LOCAL_CLOCK_POLARITY_IN[0];
            LOCAL_CLOCK_2M_OUT <= state[2] ^ LOCAL_CLOCK_POLARITY_IN[1];
            LOCAL_CLOCK_4M_OUT <= state[1] ^ LOCAL_CLOCK_POLARITY_IN[2];
            LOCAL_CLOCK_8M_OUT <= state[0] ^ LOCAL_CLOCK_POLARITY_IN[3];
            FRAME_PULSE_BAR_OUT <= frame_raw;
            BUS_MASTER_OUT <= BUS_MASTER_ENABLE_IN &&
                              CLOCK_MODE_IN != LTF_CM_SLAVE;
            APLL_SOURCE_OUT <= next_apll;
            DPLL_CLOCK_OUT <= state[1];
            LOCAL_CLOCK_STATUS_OUT <= {DMA_READ_ACK_IN, DMA_WRITE_ACK_IN,
                                       EXT_FRAME_REF_B_IN,
                                       EXT_FRAME_REF_A_IN};
            FRAME_STATE_OUT <= state;
        end
    end

    // ----------------------------------------
    // Local serial streams
    // ----------------------------------------
    logic [31:0] fifo_data, tx_word, next_tx_word;
    logic [31:0] rx_acc, next_rx_acc, next_rx_data;
    logic [3:0] next_ser;
    logic fifo_valid, fifo_pop, slot_start, slot_end, next_rx_valid;
    logic [5:0] off;

    // Source stalls on TX_READY_OUT; drain is one word per 2 Mb/s slot
    ltf_fifo #(.WIDTH(`LTF_FIFO_WIDTH), .DEPTH(`LTF_FIFO_DEPTH)) u_fifo (
        .clk(CLOCK_IN),
        .srst(SRST_IN),
        .wr_data(TX_DATA_IN),
        .wr_valid(TX_VALID_IN),
        .wr_ready(TX_READY_OUT),
        .rd_data(fifo_data),
        .rd_valid(fifo_valid),
        .rd_ready(fifo_pop)
    );

    always_comb begin
        off = state[5:0];
        slot_start = st_new && off == 6'h00;
        slot_end = st_new && off == 6'h3f;
        fifo_pop = slot_start;
        next_tx_word = tx_word;
        if (slot_start) begin
            // Underrun sends idle ones rather than stale data
            next_tx_word = fifo_valid ? fifo_data : 32'hffffffff;
        end
        next_rx_acc = rx_acc;
        for (int p = 0; p < 4; p++) begin
            ltf_rate_t r;
            logic [4:0] pos;
            r = pin_rate(SERIAL_LAYOUT_IN, p);
            pos = bit_pos(r, p, off);
            if (r == LTF_RNONE) begin
                next_ser[p] = 1'b1;
            end else begin
                next_ser[p] = next_tx_word[pos];
            end
            if (st_new && r != LTF_RNONE && cell_end(r, off)) begin
                next_rx_acc[pos] = LOCAL_SERIAL_IN[p];
            end
        end
        next_rx_valid = slot_end;
        next_rx_data = slot_end ? next_rx_acc : RX_DATA_OUT;
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            tx_word <= 32'hffffffff;
            rx_acc <= '0;
            LOCAL_SERIAL_OUT <= 4'hf;
            RX_DATA_OUT <= '0;
            RX_VALID_OUT <= 1'b0;
        end else begin
            tx_word <= next_tx_word;
            rx_acc <= next_rx_acc;
            LOCAL_SERIAL_OUT <= next_ser;
            RX_DATA_OUT <= next_rx_data;
            RX_VALID_OUT <= next_rx_valid;
        end
    end

    // ----------------------------------------
    // Framing groups
    // ----------------------------------------
    logic [11:0] next_fga, next_fgb;

    always_comb begin
        for (int i = 0; i < 12; i++) begin
            next_fga[i] = fg_bit(GROUP_A_START_IN, GROUP_A_MODE_IN, i,
                                 state, BUS_OUT_DRIVE_EN_IN);
            next_fgb[i] = fg_bit(GROUP_B_START_IN, GROUP_B_MODE_IN, i,
                                 state, BUS_IN_DRIVE_EN_IN);
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            FRAMING_GROUP_A_OUT <= '0;
            FRAMING_GROUP_B_OUT <= '0;
        end else begin
            FRAMING_GROUP_A_OUT <= next_fga;
            FRAMING_GROUP_B_OUT <= next_fgb;
        end
    end

    // ----------------------------------------
    // Throughput delay bounds, in master states
    // ----------------------------------------
    function automatic logic [11:0] slots(ltf_rate_t r, logic mx);
        unique case (r)
            LTF_R2: slots = mx ? `LTF_DMAX_2M : `LTF_DMIN_2M;
            LTF_R4: slots = mx ? `LTF_DMAX_4M : `LTF_DMIN_4M;
            default: slots = mx ? `LTF_DMAX_8M : `LTF_DMIN_8M;
        endcase
    endfunction

    always_ff @(posedge CLOCK_IN) begin
        if (SRST_IN) begin
            DELAY_MIN_OUT <= '0;
            DELAY_MAX_OUT <= '0;
        end else begin
            DELAY_MIN_OUT <= 12'(slots(DELAY_OUT_RATE_IN, 1'b0) *
                             ts_len(DELAY_OUT_RATE_IN));
            DELAY_MAX_OUT <= `LTF_FRAME_LEN + 12'(slots(DELAY_IN_RATE_IN,
                             1'b1) * ts_len(DELAY_IN_RATE_IN));
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_resync_phase: assert property (
        (CLOCK_MODE_IN == LTF_CM_P6 && $rose(EXT_FRAME_REF_A_IN) &&
         !ref_q) |=> state == 11'h000)
        else $error("frame counter not realigned to reference");
    chk_apll_source: assert property (
        CLOCK_MODE_IN inside {LTF_CM_P5, LTF_CM_P6, LTF_CM_P7} &&
        $stable(CLOCK_MODE_IN) |=> APLL_SOURCE_OUT == 2'h2)
        else $error("analog loop not fed from digital loop");
    chk_bus_master: assert property (
        !BUS_MASTER_ENABLE_IN ##1 !BUS_MASTER_ENABLE_IN |-> !BUS_MASTER_OUT)
        else $error("bus master without enable");
    chk_clock_8m: assert property (
        st_new && $past(adj) == 2'h0 && !ref_rise &&
        $stable(LOCAL_CLOCK_POLARITY_IN)
        |=> LOCAL_CLOCK_8M_OUT != $past(LOCAL_CLOCK_8M_OUT))
        else $error("8 MHz clock missed a master state");
    chk_clock_pol: assert property (
        ##1 LOCAL_CLOCK_4M_OUT ==
        ($past(state[1]) ^ $past(LOCAL_CLOCK_POLARITY_IN[2])))
        else $error("4 MHz clock polarity wrong");
    chk_status_bits: assert property (
        ##1 LOCAL_CLOCK_STATUS_OUT[1:0] ==
        $past({EXT_FRAME_REF_B_IN, EXT_FRAME_REF_A_IN}))
        else $error("status bits do not follow references");
    chk_tx_slot_msb: assert property (
        SERIAL_LAYOUT_IN == LTF_SER_ONE && slot_start && fifo_valid
        |=> LOCAL_SERIAL_OUT == {$past(fifo_data[31]),
        $past(fifo_data[23]), $past(fifo_data[15]), $past(fifo_data[7])})
        else $error("slot word not launched MSB first");
    chk_frm_static: assert property (
        GROUP_A_MODE_IN[7:6] == 2'h0 |=> FRAMING_GROUP_A_OUT ==
        {$past(GROUP_A_MODE_IN[3:0]), $past(GROUP_A_START_IN)})
        else $error("static framing levels wrong");
    chk_frm_first: assert property (
        GROUP_A_MODE_IN[7:6] == 2'h2 &&
        state == {GROUP_A_MODE_IN[2:0], GROUP_A_START_IN}
        |=> FRAMING_GROUP_A_OUT[0])
        else $error("first framing pulse missing at start state");
    chk_delay_same: assert property (
        DELAY_IN_RATE_IN == LTF_R4 && DELAY_OUT_RATE_IN == LTF_R4
        |=> DELAY_MIN_OUT == 12'h060 && DELAY_MAX_OUT == 12'h8a0)
        else $error("4 Mb/s delay bounds wrong");
endmodule
`default_nettype wire

/* testbench/ltf_codec_model.sv */
// Loopback codec model for the local serial pins
`timescale 1ns/1ps
`default_nettype none
module ltf_codec_model (
    input wire logic clk_in,
    input wire logic [3:0] ser_out_in,
    output logic [3:0] ser_in_out
);
    // Retimed echo; idle pins stay high as the block drives them
    always_ff @(posedge clk_in) begin
        ser_in_out <= ser_out_in;
    end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the local timing and framing block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ltf_pkg::*;
    logic clk, rst, mst, rs, ra, rb, dw, dr, txv, txr, rxv, lo, bf;
    logic fclk, c2, c4, c8, fpb, bm, dpll;
    ltf_clk_mode_t cm;
    ltf_ser_cfg_t sc;
    ltf_rate_t di, dq;
    logic [1:0] aps;
    logic [3:0] pol, st, si, so, idle_mask;
    logic [7:0] sa, ma, sb, mb, eo, ei;
    logic [10:0] fs, d;
    logic [11:0] fa, fb, dmin, dmax, ea, eb;
    logic [31:0] txd, rxd;
    logic [31:0] rx_q[$];
    int n_fail, check_count, seed, t;
    int mn[3] = '{128, 96, 80};
    int mx[3] = '{2176, 2208, 2224};

    ltf_top u_dut (.CLOCK_IN(clk), .SRST_IN(rst), .CLOCK_MODE_IN(cm),
        .BUS_MASTER_ENABLE_IN(mst), .BUS_FRAME_IN(bf),
        .SECONDARY_FRAME_REF_IN(rs), .EXT_FRAME_REF_A_IN(ra),
        .EXT_FRAME_REF_B_IN(rb), .DMA_WRITE_ACK_IN(dw),
        .DMA_READ_ACK_IN(dr), .LOCAL_CLOCK_POLARITY_IN(pol),
        .LOCAL_CLOCK_STATUS_OUT(st), .SERIAL_LAYOUT_IN(sc),
        .TX_DATA_IN(txd), .TX_VALID_IN(txv), .TX_READY_OUT(txr),
        .RX_DATA_OUT(rxd), .RX_VALID_OUT(rxv), .LOCAL_SERIAL_IN(si),
        .LOCAL_SERIAL_OUT(so), .GROUP_A_START_IN(sa), .GROUP_A_MODE_IN(ma),
        .GROUP_B_START_IN(sb), .GROUP_B_MODE_IN(mb),
        .BUS_OUT_DRIVE_EN_IN(eo), .BUS_IN_DRIVE_EN_IN(ei),
        .FRAMING_GROUP_A_OUT(fa), .FRAMING_GROUP_B_OUT(fb),
        .LOCAL_FRAME_CLOCK_OUT(fclk), .LOCAL_CLOCK_2M_OUT(c2),
        .LOCAL_CLOCK_4M_OUT(c4), .LOCAL_CLOCK_8M_OUT(c8),
        .FRAME_PULSE_BAR_OUT(fpb), .BUS_MASTER_OUT(bm),
        .APLL_SOURCE_OUT(aps), .DPLL_CLOCK_OUT(dpll),
        .FRAME_STATE_OUT(fs), .DELAY_IN_RATE_IN(di),
        .DELAY_OUT_RATE_IN(dq), .DELAY_MIN_OUT(dmin), .DELAY_MAX_OUT(dmax));
    ltf_codec_model u_codec (.clk_in(clk), .ser_out_in(so), .ser_in_out(si));

    // ----
    // Tasks
    // ----
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic compare_val(input logic [31:0] got, input logic [31:0] e);
        check_count++;
        if (got !== e) begin
            n_fail++;
            $display("MISMATCH %0t: got %h, expected %h", $time, got, e);
        end
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Ticks are 12-13 cycles apart, so three quiet cycles mean settled
    task automatic check_frame;
        int k;
        k = 0;
        while (k < 3) begin
            d = fs;
            @(negedge clk);
            k = (fs === d) ? k + 1 : 0;
        end
        lo = fs >= 11'h7fe || fs <= 11'h001;
        for (int i = 0; i < 12; i++) begin
            d = fs - {ma[2:0], sa};
            ea[i] = d >= i * 32 && d < i * 32 + 4;
            d = fs - {mb[2:0], sb};
            eb[i] = !(d >= i * 64 && d < i * 64 + 64);
        end
        compare_val({c8, c4, c2}, {fs[0], fs[1], fs[2]} ^ pol[3:1]);
        compare_val({dpll, c4 ^ pol[2]}, {fs[1], fs[1]});
        compare_val({fclk, fpb}, {!lo ^ pol[0], !lo});
        compare_val({fa, fb}, {ea, eb});
    endtask
    task automatic run_layout(input ltf_ser_cfg_t cfg, input logic [3:0] m);
        for (t = 0; t < 2000 && rxv !== 1'b1; t++) @(negedge clk);
        @(posedge clk);
        sc <= cfg;
        // Idle check waits until the new layout has settled on the pins
        idle_mask <= 4'h0;
        for (int i = 0; i < 9; i++) begin
            txd <= $random(seed);
            txv <= 1'b1;
            @(negedge clk);
            compare_val(txr, i < 8);
            if (i < 8) rx_q.push_back(txd);
            @(posedge clk);
        end
        txv <= 1'b0;
        idle_mask <= m;
        for (t = 0; t < 10000 && rx_q.size() > 0; t++) @(posedge clk);
        compare_val(rx_q.size(), 0);
        $display("Layout %0d done", cfg);
    endtask

    // Outputs are looked at mid-cycle, clear of the launching edge
    always @(negedge clk) begin
        if (rxv === 1'b1 && rxd !== '1 && rx_q.size() > 0)
            compare_val(rxd, rx_q.pop_front());
        if (idle_mask != 0)
            compare_val(so & idle_mask, idle_mask);
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Whole run needs roughly 32k cycles
    initial begin
        #500000;
        n_fail++;
        complete_run;
    end

    // ----
    // Sequence
    // ----
    initial begin
        seed = 76588;
        rst = 1'b1;
        {mst, rs, ra, rb, dw, dr, txv} = '0;
        bf = 1'b1;
        cm = LTF_CM_FREE;
        sc = LTF_SER_ONE;
        di = LTF_R2;
        dq = LTF_R2;
        {pol, idle_mask, sa, ma, sb, mb, eo, ei, txd} = '0;
        cyc(5);
        #1;
        compare_val({so, txr, bm, fclk, c2}, 8'hfa);
        compare_val({fa, fb}, '0);
        compare_val({dmin, dmax}, '0);
        @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            {ra, rb, dw, dr, mst} <= 5'($random(seed));
            {sa, sb, eo, ei} <= $random(seed);
            ma <= {1'b0, i[0], 6'($random(seed))};
            mb <= {1'b0, i[0], 6'($random(seed))};
            cyc(2);
            #1;
            ea = ma[6] ? {~eo, sa[3:0]} : {ma[3:0], sa};
            eb = mb[6] ? {~ei, sb[3:0]} : {mb[3:0], sb};
            compare_val({st, bm}, {dr, dw, rb, ra, mst});
            compare_val({fa, fb}, {ea, eb});
        end
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            di <= ltf_rate_t'(2'(i / 3));
            dq <= ltf_rate_t'(2'(i % 3));
            cyc(2);
            #1;
            compare_val({dmin, dmax}, {12'(mn[i % 3]), 12'(mx[i / 3])});
        end
        $display("Static and delay tests done");
        run_layout(LTF_SER_ONE, 4'h0);
        run_layout(LTF_SER_TWO, 4'ha);
        run_layout(LTF_SER_THREE, 4'he);
        run_layout(LTF_SER_FOUR, 4'h8);
        @(posedge clk);
        idle_mask <= 4'h0;
        {ma[2:0], sa} <= fs + 11'd8;
        {mb[2:0], sb} <= fs - 11'd700;
        ma[7:3] <= 5'b10010;
        mb[7:3] <= 5'b11001;
        for (int i = 0; i < 200; i++) begin
            if (i % 50 == 0) begin
                pol <= 4'($random(seed));
                cyc(30);
            end
            check_frame;
            cyc(10);
        end
        $display("Clock and framing test done");
        for (int m = 0; m < 8; m++) begin
            @(posedge clk);
            cm <= ltf_clk_mode_t'(3'(m));
            mst <= 1'b1;
            bf <= 1'b1;
            {rs, ra, rb} <= 3'h0;
            cyc(3);
            for (t = 0; t < 30000 && (fs < 16 || fs > 1000); t++) cyc(1);
            {rs, ra, rb} <= 3'(8 >> (m % 4));
            // Bus slave mode aligns on the falling backplane frame
            bf <= (m != 4);
            cyc(6);
            #1;
            if (m != 0) compare_val(fs == 0, m >= 4);
            ea[2:0] = {m == 0 ? 2'h0 : m == 4 ? 2'h1 : 2'h2, m != 4};
            compare_val({aps, bm}, ea[2:0]);
        end
        $display("Clock mode test done");
        complete_run;
    end
endmodule
`default_nettype wire
